/* design/smmsc_map.svh */
`ifndef SMMSC_MAP_SVH
`define SMMSC_MAP_SVH

// Number of clocks a pin must be seen asserted before the next asserted clock accepts it.
`define SMMSC_FILTER_LEN 2
`define SMMSC_FILTER_LEN_W 2
// Counter width used while writing state to management memory.
`define SMMSC_SAVE_CNT_W 4
// Number of words written to management memory when saving state.
`define SMMSC_SAVE_WORDS 4'h8

`endif

/* design/smmsc_pkg.sv */
package smmsc_pkg;
    typedef enum logic [3:0] {
        RUN = 4'h0,
        SM_FLUSH = 4'h1,
        SM_DRAIN = 4'h2,
        SM_SAVE = 4'h3,
        SM_INTOFF = 4'h4,
        SM_JUMP = 4'h5,
        SM_ACTIVE = 4'h6,
        SG_FLUSH = 4'h7,
        SG_DRAIN = 4'h8,
        SG_CYCLE = 4'h9,
        SG_WAIT = 4'ha,
        SG_STOPPED = 4'hb
    } smmsc_state_e;
endpackage

/* design/smmsc_filter.sv */
`timescale 1ns/1ps
`include "smmsc_map.svh"

// Accepts a request level only once it has been stable for the filter length.
module smmsc_filter (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Request
    input wire logic i_req,
    output logic o_level,
    output logic o_rise
);
    logic [`SMMSC_FILTER_LEN_W-1:0] cnt_q;
    logic level_q;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q <= 2'h0;
        end else if (i_ce) begin
            if (!i_req) begin
                cnt_q <= 2'h0;
            end else if (cnt_q != 2'(`SMMSC_FILTER_LEN)) begin
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            level_q <= 1'b0;
        end else if (i_ce) begin
            if (!i_req) begin
                level_q <= 1'b0;
            end else if (cnt_q == 2'(`SMMSC_FILTER_LEN)) begin
                level_q <= 1'b1;
            end
        end
    end

    assign o_level = level_q;
    assign o_rise = i_ce && i_req && (cnt_q == 2'(`SMMSC_FILTER_LEN)) && !level_q;
endmodule // smmsc_filter

/* design/smmsc_entry.sv */
// Behaviour
// - An accepted management request moves the device into management mode.
// - A management request flushes the pipeline, drains the bus, then asserts the active pin.
// - After the active pin, state is saved, then interrupts disabled, then the handler entered.
// - The asserted active pin tells external logic the device is in management mode.
// - An asserted stop request moves the device into stop grant with the core clock halted.
// - A stop request flushes the pipeline, drains the bus, then runs a stop grant special cycle.
// - The core clock is gated only after burst ready and write buffer empty are both seen.
// - External logic may halt the bus clock in stop grant; the device then is in stop clock.
`timescale 1ns/1ps
`include "smmsc_map.svh"

module smmsc_entry (
    // Clock, reset and enable
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Request pins
    input wire logic i_smm_request_n,
    input wire logic i_clock_stop_request_n,
    // Bus handshake pins
    input wire logic i_burst_ready_n,
    input wire logic i_write_buffer_empty_n,
    // Core status
    input wire logic i_pipe_empty,
    input wire logic i_bus_idle,
    input wire logic i_resume,
    // Core control
    output logic o_pipe_flush,
    output logic o_bus_hold_new,
    output logic o_save_we,
    output logic [`SMMSC_SAVE_CNT_W-1:0] o_save_addr,
    output logic o_int_disable,
    output logic o_handler_jump,
    output logic o_core_clk_en,
    // Bus pins
    output logic o_smm_active_n,
    output logic o_stop_grant_cycle,
    // Status
    output logic o_management_mode,
    output logic o_stop_grant
);
    smmsc_pkg::smmsc_state_e state_q;
    smmsc_pkg::smmsc_state_e state_d;
    logic smi_lvl;
    logic smi_rise;
    logic stp_lvl;
    logic [`SMMSC_SAVE_CNT_W-1:0] save_q;
    logic smm_active_n_q;
    logic int_dis_q;
    logic jump_q;
    logic sg_cycle_q;
    logic smi_pend_q;

    // The management request is edge sensitive: remember a rising edge until served.
    smmsc_filter u_smi (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_req(!i_smm_request_n),
        .o_level(smi_lvl),
        .o_rise(smi_rise)
    );

    // Stop requests are level sensitive; the filter enforces the three-clock width.
    smmsc_filter u_stp (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_req(!i_clock_stop_request_n),
        .o_level(stp_lvl),
        .o_rise()
    );

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            smi_pend_q <= 1'b0;
        end else if (i_ce) begin
            if (smi_rise) begin
                smi_pend_q <= 1'b1;
            end else if (state_q == smmsc_pkg::SM_FLUSH) begin
                smi_pend_q <= 1'b0;
            end
        end
    end

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            smmsc_pkg::RUN: begin
                // Management requests win over stop requests when both are pending.
                if (smi_pend_q) begin
                    state_d = smmsc_pkg::SM_FLUSH;
                end else if (stp_lvl) begin
                    state_d = smmsc_pkg::SG_FLUSH;
                end
            end
            smmsc_pkg::SM_FLUSH: begin
                if (i_pipe_empty) begin
                    state_d = smmsc_pkg::SM_DRAIN;
                end
            end
            smmsc_pkg::SM_DRAIN: begin
                if (i_bus_idle) begin
                    state_d = smmsc_pkg::SM_SAVE;
                end
            end
            smmsc_pkg::SM_SAVE: begin
                if (save_q == `SMMSC_SAVE_WORDS - 4'h1) begin
                    state_d = smmsc_pkg::SM_INTOFF;
                end
            end
            smmsc_pkg::SM_INTOFF: state_d = smmsc_pkg::SM_JUMP;
            smmsc_pkg::SM_JUMP: state_d = smmsc_pkg::SM_ACTIVE;
            smmsc_pkg::SM_ACTIVE: begin
                if (i_resume) begin
                    state_d = smmsc_pkg::RUN;
                end
            end
            smmsc_pkg::SG_FLUSH: begin
                if (i_pipe_empty) begin
                    state_d = smmsc_pkg::SG_DRAIN;
                end
            end
            smmsc_pkg::SG_DRAIN: begin
                if (i_bus_idle) begin
                    state_d = smmsc_pkg::SG_CYCLE;
                end
            end
            smmsc_pkg::SG_CYCLE: begin
                if (!i_burst_ready_n) begin
                    state_d = smmsc_pkg::SG_WAIT;
                end
            end
            smmsc_pkg::SG_WAIT: begin
                if (!i_write_buffer_empty_n) begin
                    state_d = smmsc_pkg::SG_STOPPED;
                end
            end
            smmsc_pkg::SG_STOPPED: begin
                // A stopped bus clock simply freezes this state: that is stop clock.
                if (!stp_lvl) begin
                    state_d = smmsc_pkg::RUN;
                end
            end
            default: state_d = smmsc_pkg::RUN;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= smmsc_pkg::RUN;
        end else if (i_ce) begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            save_q <= 4'h0;
        end else if (i_ce) begin
            if (state_q == smmsc_pkg::SM_SAVE) begin
                save_q <= save_q + 4'h1;
            end else begin
                save_q <= 4'h0;
            end
        end
    end

    // The acknowledge stays asserted until the handler resumes normal work.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            smm_active_n_q <= 1'b1;
        end else if (i_ce) begin
            if (state_q == smmsc_pkg::SM_DRAIN && i_bus_idle) begin
                smm_active_n_q <= 1'b0;
            end else if (state_q == smmsc_pkg::SM_ACTIVE && i_resume) begin
                smm_active_n_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            int_dis_q <= 1'b0;
        end else if (i_ce) begin
            if (state_q == smmsc_pkg::SM_INTOFF) begin
                int_dis_q <= 1'b1;
            end else if (state_q == smmsc_pkg::SM_ACTIVE && i_resume) begin
                int_dis_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            jump_q <= 1'b0;
        end else if (i_ce) begin
            jump_q <= (state_q == smmsc_pkg::SM_JUMP);
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sg_cycle_q <= 1'b0;
        end else if (i_ce) begin
            sg_cycle_q <= (state_d == smmsc_pkg::SG_CYCLE);
        end
    end

    assign o_pipe_flush = (state_q == smmsc_pkg::SM_FLUSH) || (state_q == smmsc_pkg::SG_FLUSH);
    assign o_bus_hold_new = (state_q != smmsc_pkg::RUN) && (state_q != smmsc_pkg::SM_ACTIVE);
    assign o_save_we = (state_q == smmsc_pkg::SM_SAVE);
    assign o_save_addr = save_q;
    assign o_int_disable = int_dis_q;
    assign o_handler_jump = jump_q;
    assign o_core_clk_en = (state_q != smmsc_pkg::SG_STOPPED);
    assign o_smm_active_n = smm_active_n_q;
    assign o_stop_grant_cycle = sg_cycle_q;
    assign o_management_mode = !smm_active_n_q;
    assign o_stop_grant = (state_q == smmsc_pkg::SG_STOPPED);
endmodule // smmsc_entry

/* test/smmsc_chipset.sv */
`timescale 1ns/1ps
module smmsc_chipset (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Bench controls
    input wire logic [3:0] i_delay,
    input wire logic i_buf_busy,
    // Bus pins
    input wire logic i_stop_grant_cycle,
    output logic o_burst_ready_n,
    output logic o_write_buffer_empty_n
);
    logic [3:0] cnt_q;
    // Ready is a one-cycle strobe, so a stale ready can never complete a later cycle.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q <= 4'h0;
            o_burst_ready_n <= 1'b1;
            o_write_buffer_empty_n <= 1'b1;
        end else begin
            o_burst_ready_n <= 1'b1;
            o_write_buffer_empty_n <= i_buf_busy;
            cnt_q <= 4'h0;
            if (i_stop_grant_cycle && o_burst_ready_n) begin
                cnt_q <= cnt_q + 4'h1;
                o_burst_ready_n <= (cnt_q != i_delay);
            end
        end
    end
endmodule // smmsc_chipset

/* test/smmsc_checker.sv */
`timescale 1ns/1ps
module smmsc_checker (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Watched pins
    input wire logic i_clock_stop_request_n,
    input wire logic i_burst_ready_n,
    input wire logic i_pipe_empty,
    input wire logic o_pipe_flush,
    input wire logic i_write_buffer_empty_n,
    input wire logic i_bus_idle,
    input wire logic o_save_we,
    input wire logic o_int_disable,
    input wire logic o_handler_jump,
    input wire logic o_core_clk_en,
    input wire logic o_smm_active_n,
    input wire logic o_stop_grant_cycle,
    input wire logic o_stop_grant
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    property p_gate_after_empty;
        $fell(o_core_clk_en) |-> !$past(i_write_buffer_empty_n) && !o_stop_grant_cycle;
    endproperty
    property p_grant_gated;
        o_stop_grant |-> !o_core_clk_en && !o_stop_grant_cycle && o_smm_active_n;
    endproperty
    property p_grant_holds;
        o_stop_grant && !i_clock_stop_request_n |=> o_stop_grant;
    endproperty
    property p_restart;
        $rose(i_clock_stop_request_n) && o_stop_grant |-> ##[1:5] o_core_clk_en;
    endproperty
    property p_cycle_until_ready;
        o_stop_grant_cycle && i_burst_ready_n |=> o_stop_grant_cycle;
    endproperty
    chk_ack_bus_idle: assert property ($fell(o_smm_active_n) |-> $past(i_bus_idle))
        else $error("ack before bus drained");
    chk_save_in_mode: assert property (o_save_we |-> !o_smm_active_n && !o_int_disable)
        else $error("save out of order");
    chk_jump_after_off: assert property (o_handler_jump |-> o_int_disable && !o_save_we)
        else $error("jump out of order");
    chk_jump_pulse: assert property (o_handler_jump |=> !o_handler_jump)
        else $error("jump not a pulse");
    chk_gate_handshake: assert property (p_gate_after_empty)
        else $error("clock gated early");
    chk_cycle_bus_idle: assert property ($rose(o_stop_grant_cycle) |-> $past(i_bus_idle))
        else $error("grant cycle before drain");
    chk_grant_gated: assert property (p_grant_gated)
        else $error("grant with clock on");
    chk_grant_holds: assert property (p_grant_holds)
        else $error("grant left while requested");
    chk_restart_bound: assert property (p_restart)
        else $error("no restart");
    chk_flush_until_empty: assert property (o_pipe_flush && !i_pipe_empty |=> o_pipe_flush)
        else $error("flush left early");
    chk_cycle_until_ready: assert property (p_cycle_until_ready)
        else $error("grant cycle ended before ready");
    cover property ($fell(o_smm_active_n));
    cover property ($fell(o_core_clk_en));
    cover property (o_handler_jump);
endmodule // smmsc_checker

bind smmsc_entry smmsc_checker u_chk (.i_clk, .i_nrst, .i_clock_stop_request_n,
    .i_burst_ready_n, .i_pipe_empty, .o_pipe_flush,
    .i_write_buffer_empty_n, .i_bus_idle, .o_save_we, .o_int_disable, .o_handler_jump,
    .o_core_clk_en, .o_smm_active_n, .o_stop_grant_cycle, .o_stop_grant);

/* test/smmsc_entry_bench.sv */
`timescale 1ns/1ps
module smmsc_entry_bench;
    logic i_clk = 1'b0;
    logic run = 1'b1;
    logic i_nrst = 1'b0;
    logic smm_request_n = 1'b1;
    logic clock_stop_request_n = 1'b1;
    logic pipe_empty = 1'b0;
    logic bus_idle = 1'b0;
    logic resume = 1'b0;
    logic buf_busy = 1'b1;
    logic [3:0] delay = 4'h0;
    logic burst_ready_n_n, wbe_n, flush, save_we, int_off, jump, clk_en, act_n, sg_cyc, mm, sg, hold;
    logic [3:0] addr;
    int err_count = 0;
    int tests_run = 0;
    initial forever #5 if (run) i_clk = ~i_clk;
    smmsc_chipset u_cs (.i_clk(i_clk), .i_nrst(i_nrst), .i_delay(delay), .i_buf_busy(buf_busy),
        .i_stop_grant_cycle(sg_cyc), .o_burst_ready_n(burst_ready_n_n), .o_write_buffer_empty_n(wbe_n));
    smmsc_entry uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1),
        .i_smm_request_n(smm_request_n), .i_clock_stop_request_n(clock_stop_request_n),
        .i_burst_ready_n(burst_ready_n_n), .i_write_buffer_empty_n(wbe_n), .i_pipe_empty(pipe_empty),
        .i_bus_idle(bus_idle), .i_resume(resume), .o_pipe_flush(flush), .o_bus_hold_new(hold),
        .o_save_we(save_we), .o_save_addr(addr), .o_int_disable(int_off), .o_handler_jump(jump),
        .o_core_clk_en(clk_en), .o_smm_active_n(act_n), .o_stop_grant_cycle(sg_cyc),
        .o_management_mode(mm), .o_stop_grant(sg));
    task automatic check(input logic seen, input logic exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %b expected %b", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("tests %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    function automatic logic probe(input int s);
        case (s)
            0: return flush;
            1: return act_n;
            2: return sg_cyc;
            default: return clk_en;
        endcase
    endfunction
    // Samples 1 ns after the edge so the design's own updates have landed.
    task automatic wait_for(input int s, input logic v);
        for (int k = 0; k < 60 && probe(s) !== v; k++) begin
            @(posedge i_clk);
            #1;
        end
        if (probe(s) !== v) begin
            err_count++;
            $display("[FAIL] %0t wait limit reached", $time);
            print_verdict();
        end
    endtask
    task automatic test_smm();
        int n = 0;
        @(posedge i_clk);
        smm_request_n <= 1'b0;
        wait_for(0, 1'b1);
        repeat (3) @(posedge i_clk);
        #1 check(act_n, 1'b1);
        @(posedge i_clk);
        pipe_empty <= 1'b1;
        repeat (4) @(posedge i_clk);
        #1 check(act_n, 1'b1);
        check(hold, 1'b1);
        @(posedge i_clk);
        bus_idle <= 1'b1;
        wait_for(1, 1'b0);
        check(mm, 1'b1);
        for (int k = 0; k < 40 && jump !== 1'b1; k++) begin
            if (save_we === 1'b1) begin
                check(addr === 4'(n), 1'b1);
                n++;
            end
            @(posedge i_clk);
            #1;
        end
        check(jump, 1'b1);
        check(n == 8, 1'b1);
        check(int_off, 1'b1);
        check(hold, 1'b0);
        @(posedge i_clk);
        smm_request_n <= 1'b1;
        resume <= 1'b1;
        @(posedge i_clk);
        resume <= 1'b0;
        wait_for(1, 1'b1);
        check(mm, 1'b0);
        $display("test smm entry done");
    endtask
    task automatic test_stop(input logic [3:0] d);
        @(posedge i_clk);
        delay <= d;
        pipe_empty <= 1'b0;
        bus_idle <= 1'b0;
        clock_stop_request_n <= 1'b0;
        wait_for(0, 1'b1);
        repeat (2) @(posedge i_clk);
        #1 check(sg_cyc, 1'b0);
        @(posedge i_clk);
        pipe_empty <= 1'b1;
        repeat (3) @(posedge i_clk);
        #1 check(sg_cyc, 1'b0);
        check(hold, 1'b1);
        @(posedge i_clk);
        bus_idle <= 1'b1;
        wait_for(2, 1'b1);
        check(clk_en, 1'b1);
        wait_for(2, 1'b0);
        repeat (3) @(posedge i_clk);
        #1 check(clk_en, 1'b1);
        @(posedge i_clk);
        buf_busy <= 1'b0;
        wait_for(3, 1'b0);
        check(sg, 1'b1);
        run = 1'b0;
        #200 run = 1'b1;
        check(sg, 1'b1);
        check(clk_en, 1'b0);
        @(posedge i_clk);
        clock_stop_request_n <= 1'b1;
        buf_busy <= 1'b1;
        wait_for(3, 1'b1);
        check(sg, 1'b0);
        $display("test stop grant done");
    endtask
    // A reset in the middle of an entry must drop every status output back to idle.
    task automatic test_reset();
        @(posedge i_clk);
        smm_request_n <= 1'b0;
        wait_for(1, 1'b0);
        @(posedge i_clk);
        i_nrst <= 1'b0;
        smm_request_n <= 1'b1;
        #1 check(act_n, 1'b1);
        check(mm, 1'b0);
        check(int_off, 1'b0);
        check(clk_en, 1'b1);
        check(sg, 1'b0);
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (4) @(posedge i_clk);
        #1 check(flush, 1'b0);
        check(act_n, 1'b1);
        $display("test reset done");
    endtask
    initial begin
        repeat (10) @(posedge i_clk);
        i_nrst <= 1'b1;
        test_smm();
        test_stop(4'h0);
        test_stop(4'h3);
        test_reset();
        print_verdict();
    end
endmodule // smmsc_entry_bench
